// ---- inc/sar_ctrl_pkg.sv ----
// Constants and types shared by the converter control logic.
// Assumes a single 50 MHz clock; all pins but bipolar enter through synchronisers.
//
// Overview of operation
// - Falling conversion start edge begins a conversion
// - Start ignored unless chip select is low
// - Drive result only when read and select low
// - Busy low during conversion, high otherwise
// - Power-down input low enters power-down state
// - Approximation register cleared but for the MSB at conversion start
// - Start edges during conversion are ignored
// - One bit per step, MSB down to LSB
// - Completed register copied into output latches
// - Result bit eleven is the MSB
// - Unipolar straight binary, bipolar two's complement
package sar_ctrl_pkg;

    // ==========================================================
    // Sizes and timing
    localparam int RESULT_W = 12;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS = 1400;
    // Conversion time split over the bit steps, longest time rounds down
    localparam int STEP_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS) / RESULT_W;
    localparam int STEP_W = 4;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] BIT_MSB = BIT_W'(RESULT_W - 1);
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_LATCH
    } conv_state_t;

endpackage

// ---- rtl/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to the clock.
`timescale 1ns/1ns
module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic pin_in,
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_t;

    sync_t q;
    sync_t d;

    // ==========================================================
    // Next state: the level only moves once stages two and three agree
    always_comb
    begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3)
        begin
            d.level = q.s3;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q <= {4{RST_VAL}};
        end
        else
        begin
            q <= d;
        end
    end

    assign level_out = q.level;

endmodule // pin_sync

// ---- rtl/sar_adc_control_interface.sv ----
// Control sequencer of a 12-bit successive-approximation converter.
// Holds pin synchronisers, a self-timed bit sequencer, the output latch
// and the enables of the result bus drivers.
// Assumes the comparator decision arrives as a level on this clock.
// Assumes the analog core follows the trial code with no added delay.
`timescale 1ns/1ns
module sar_adc_control_interface
    import sar_ctrl_pkg::*;
#(
    parameter int WIDTH = sar_ctrl_pkg::RESULT_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic chip_select_n_in,
    input wire logic conv_start_n_in,
    input wire logic read_n_in,
    input wire logic power_down_n_in,
    input wire logic bipolar_in,
    input wire logic comp_high_in,
    output logic busy_n_out,
    output logic [sar_ctrl_pkg::RESULT_W-1:0] result_out,
    output logic [sar_ctrl_pkg::RESULT_W-1:0] result_oe_out,
    output logic [sar_ctrl_pkg::RESULT_W-1:0] dac_code_out,
    output logic powered_down_out
);
    import sar_ctrl_pkg::*;

    // All sequencer state in one word, registered by a single process
    typedef struct packed {
        conv_state_t state;
        logic start_prev;
        logic [RESULT_W-1:0] approx_register;
        logic [BIT_W-1:0] bit_idx;
        logic [STEP_W-1:0] step_cnt;
        logic [RESULT_W-1:0] result_latch;
        logic busy_n;
        logic [RESULT_W-1:0] oe;
        logic pd;
    } ctrl_t;

    // Registered state and its next value
    ctrl_t q;
    ctrl_t d;
    // Pin levels after synchronisation, all active low but the comparator
    logic cs_n_s;
    logic start_n_s;
    logic rd_n_s;
    logic pd_n_s;
    logic comp_s;
    logic start_fall;

    // ==========================================================
    // Pin synchronisers
    // Each pin is seen four edges after it moves. The control pins reset to
    // their idle high level, so the release of reset shows no false edge.
    // The comparator crosses from the analog core and is filtered the same
    // way; each bit step is long enough to cover that latency.
    // Limitation: a pin pulse shorter than two clocks may be missed.

    // Chip select
    pin_sync #(
        .RST_VAL(1'b1)
    ) u_cs (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(chip_select_n_in),
        .level_out(cs_n_s)
    );

    // Conversion start
    pin_sync #(
        .RST_VAL(1'b1)
    ) u_st (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(conv_start_n_in),
        .level_out(start_n_s)
    );

    // Read strobe
    pin_sync #(
        .RST_VAL(1'b1)
    ) u_rd (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(read_n_in),
        .level_out(rd_n_s)
    );

    // Power-down request
    pin_sync #(
        .RST_VAL(1'b1)
    ) u_pd (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(power_down_n_in),
        .level_out(pd_n_s)
    );

    // Comparator decision, low from reset until the pin has passed the filter
    pin_sync #(
        .RST_VAL(1'b0)
    ) u_cmp (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(comp_high_in),
        .level_out(comp_s)
    );

    // ==========================================================
    // Start edge detect
    // A start held low through busy makes no second edge afterwards
    // Start edge only counts while chip select is low
    assign start_fall = q.start_prev && !start_n_s && !cs_n_s;

    // ==========================================================
    // Output format
    // Two's complement is straight binary with the MSB inverted
    function automatic logic [RESULT_W-1:0] fmt_code(input logic [RESULT_W-1:0] raw,
                                                      input logic bip);
        fmt_code = bip ? {~raw[RESULT_W-1], raw[RESULT_W-2:0]} : raw;
    endfunction

    // ==========================================================
    // Sequencer
    // Idle waits for a gated start, convert walks the bits, latch hands over
    always_comb
    begin
        d = q;
        d.start_prev = start_n_s;
        d.pd = !pd_n_s;
        // Bus drivers follow read and select together, each bit alike
        d.oe = {RESULT_W{!rd_n_s && !cs_n_s}};
        unique case (q.state)
            ST_IDLE:
            begin
                d.busy_n = 1'b1;
                // Power-down blocks new conversions; the latch keeps its data
                // A start seen while powered down is lost, not held for later
                if (start_fall && pd_n_s)
                begin
                    d.state = ST_CONVERT;
                    d.approx_register = '0;
                    d.approx_register[RESULT_W-1] = 1'b1;
                    d.bit_idx = BIT_MSB;
                    d.step_cnt = '0;
                    d.busy_n = 1'b0;
                end
            end
            ST_CONVERT:
            begin
                // Start edges are not looked at here, so no restart
                // Five cycles a step: four for the comparator to pass its
                // synchroniser, one to capture it; a shorter step reads stale data
                d.busy_n = 1'b0;
                d.step_cnt = q.step_cnt + STEP_W'(1);
                if (q.step_cnt == STEP_LAST)
                begin
                    d.step_cnt = '0;
                    // Clear the trial bit when the input lies below the DAC
                    d.approx_register[q.bit_idx] = comp_s;
                    if (q.bit_idx == '0)
                    begin
                        d.state = ST_LATCH;
                    end
                    else
                    begin
                        d.approx_register[q.bit_idx - BIT_W'(1)] = 1'b1;
                        d.bit_idx = q.bit_idx - BIT_W'(1);
                    end
                end
            end
            ST_LATCH:
            begin
                // Latch one cycle ahead of busy so data is ready first
                // Busy stays low here; it rises on the next edge from idle
                d.result_latch = fmt_code(q.approx_register, bipolar_in);
                d.state = ST_IDLE;
                d.busy_n = 1'b0;
            end
            default:
            begin
                d.state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    // Reset leaves the bus undriven and busy high, as after a conversion
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q.state <= ST_IDLE;
            q.start_prev <= 1'b1;
            q.approx_register <= RESULT_RST;
            q.bit_idx <= '0;
            q.step_cnt <= '0;
            q.result_latch <= RESULT_RST;
            q.busy_n <= 1'b1;
            q.oe <= '0;
            q.pd <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs, each straight from a flop of the state word
    // Bit order kept straight: index 11 is the MSB
    assign result_out = q.result_latch;
    assign result_oe_out = q.oe;
    assign busy_n_out = q.busy_n;
    assign dac_code_out = q.approx_register;
    assign powered_down_out = q.pd;

endmodule // sar_adc_control_interface

// ---- test/analog_model.sv ----
// Comparator stand-in for the analog core.
// Assumes the trial code and input level are plain binary.
`timescale 1ns/1ns
module analog_model (
    input wire logic [11:0] dac_in,
    input wire logic [11:0] level_in,
    output logic comp_out
);
    // Ideal compare, no offset, so the search lands on the level
    assign comp_out = level_in >= dac_in;
endmodule // analog_model

// ---- test/sar_adc_control_interface_properties.sv ----
// Port assertions for the converter sequencer.
// Assumes it is bound to the sequencer top.
`timescale 1ns/1ns
module sar_ctrl_checker (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic chip_select_n_in,
    input wire logic conv_start_n_in,
    input wire logic read_n_in,
    input wire logic power_down_n_in,
    input wire logic busy_n_out,
    input wire logic [11:0] result_out,
    input wire logic [11:0] result_oe_out,
    input wire logic [11:0] dac_code_out,
    input wire logic powered_down_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================
    // Framing, search order, pins
    a_busy_span: assert property (
        $fell(busy_n_out) |-> ##62 $rose(busy_n_out)) else $error("busy span");
    a_msb_first: assert property (
        $fell(busy_n_out) |-> dac_code_out == 12'h800) else $error("first trial");
    a_step_hold: assert property (
        $fell(busy_n_out) |=> $stable(dac_code_out) [*3]) else $error("step hold");
    a_start_gate: assert property (
        $fell(busy_n_out) |-> $past(!chip_select_n_in && power_down_n_in, 5))
        else $error("ungated start");
    a_result_ready: assert property (
        $rose(busy_n_out) |-> $stable(result_out)) else $error("late result");
    a_oe_read: assert property (
        result_oe_out[0] |-> $past(!read_n_in && !chip_select_n_in, 5)) else $error("drive");
    a_oe_whole: assert property (
        result_oe_out == 12'h000 || result_oe_out == 12'hfff) else $error("split oe");
    a_pd_entry: assert property (
        $fell(power_down_n_in) && busy_n_out |-> ##[3:6] powered_down_out) else $error("pd");
endmodule // sar_ctrl_checker

bind sar_adc_control_interface sar_ctrl_checker chk (.ref_clk_in, .rst_b_in,
    .chip_select_n_in, .conv_start_n_in, .read_n_in, .power_down_n_in, .busy_n_out,
    .result_out, .result_oe_out, .dac_code_out, .powered_down_out);

// ---- test/sar_adc_control_interface_tb.sv ----
// Self-checking bench for the converter sequencer.
// Assumes the comparator model closes the loop on the trial code.
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module sar_adc_control_interface_tb;
    logic ref_clk_in = 1'b0, rst_b_in = 1'b0, cs_n = 1'b1, start_n = 1'b1;
    logic read_n = 1'b1, pd_n = 1'b1, bip = 1'b0, comp, busy_n, pd_flag;
    logic [11:0] result, oe, dac, level = 12'h000;
    int fail_count = 0, compares = 0, cycles = 0, seed = 32'hb4e7332a, n;
    logic [11:0] exp_q[$];
    // ==========================================
    // Clock, partner, design
    initial forever #10 ref_clk_in = ~ref_clk_in;
    analog_model amod (.dac_in(dac), .level_in(level), .comp_out(comp));
    sar_adc_control_interface DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .chip_select_n_in(cs_n), .conv_start_n_in(start_n), .read_n_in(read_n),
        .power_down_n_in(pd_n), .bipolar_in(bip), .comp_high_in(comp), .busy_n_out(busy_n),
        .result_out(result), .result_oe_out(oe), .dac_code_out(dac),
        .powered_down_out(pd_flag));
    // Hang guard, far above nine conversions
    always @(posedge ref_clk_in)
        if (++cycles == 5000)
        begin
            fail_count++;
            final_report();
        end
    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Reference model: a bipolar input sits half scale below the level,
    // and its code is that signed value in two's complement
    function automatic logic [11:0] model_code(input int lv, input bit b);
        int v;
        v = b ? lv - (1 << (sar_ctrl_pkg::RESULT_W - 1)) : lv;
        return 12'(v);
    endfunction
    // Poll busy at falling edges so outputs have settled
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 100 && busy_n !== lvl; i++) @(negedge ref_clk_in);
        `CHK(busy_n, lvl)
    endtask
    // With again set, a second start edge lands mid-conversion and is held low
    // until busy rises; it must neither restart nor disturb the conversion
    task automatic convert(input logic [11:0] lv, input logic b, input logic again);
        logic [11:0] exp_v;
        @(posedge ref_clk_in) level <= lv;
        bip <= b;
        cs_n <= 1'b0;
        exp_q.push_back(model_code(lv, b));
        @(posedge ref_clk_in) start_n <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        start_n <= 1'b1;
        if (again)
        begin
            repeat (2) @(posedge ref_clk_in);
            start_n <= 1'b0;
        end
        wait_busy(1'b0);
        wait_busy(1'b1);
        exp_v = exp_q.pop_front();
        `CHK(result, exp_v)
        `CHK(oe, 12'h000)
        @(posedge ref_clk_in) read_n <= 1'b0;
        start_n <= 1'b1;
        repeat (6) @(negedge ref_clk_in);
        `CHK(oe, 12'hfff)
        @(posedge ref_clk_in) read_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (12) @(posedge ref_clk_in);
    endtask
    // Start pulse that must be ignored
    task automatic refused(input logic c, input logic p);
        @(posedge ref_clk_in) cs_n <= c;
        pd_n <= p;
        repeat (8) @(posedge ref_clk_in);
        start_n <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        start_n <= 1'b1;
        repeat (10) @(negedge ref_clk_in);
        `CHK(busy_n, 1'b1)
        `CHK(pd_flag, ~p)
        @(posedge ref_clk_in) cs_n <= 1'b1;
        pd_n <= 1'b1;
        repeat (20) @(posedge ref_clk_in);
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        convert(12'h000, 1'b0, 1'b0);
        convert(12'hfff, 1'b1, 1'b1);
        for (n = 0; n < 6; n++)
            convert(12'($random(seed)), n[0], n[1]);
        refused(1'b1, 1'b1);
        refused(1'b0, 1'b0);
        convert(12'h800, 1'b0, 1'b0);
        final_report();
    end
endmodule // sar_adc_control_interface_tb
